// ==== design/ddrmap_pkg.sv ====
// shared constants and types for the dual-channel ddr2 mapping core
package ddrmap_pkg;

  // ****************************************
  // geometry
  // ****************************************
  localparam int          ADDR_W        = 33;          // 8 GB byte space
  localparam logic [33:0] MAX_BYTES     = 34'h200000000;
  localparam int          LINE_BIT      = 6;           // 64 byte line
  localparam int          DATA_W        = 64;
  localparam int          ECC_W         = 8;
  localparam int          BURST_LEN     = 8;
  localparam int          MAX_OPEN_PG   = 64;
  localparam int          BANKS_SMALL   = 4;
  localparam int          BANKS_LARGE   = 8;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ        = 250;
  localparam int REFI_NS        = 7800;                // average refresh interval
  localparam int REFI_CYC       = (REFI_NS * CLK_MHZ) / 1000;
  localparam int REF_EARLY_CYC  = REFI_CYC / 2;        // opportunistic window opens
  localparam int PG_SETTLE_CYC  = 16;                  // clocks held off after power good

  // ****************************************
  // encodings
  // ****************************************
  typedef enum logic [1:0] {DDRMAP_SINGLE, DDRMAP_ASYM, DDRMAP_INTLV} ddrmap_mode_t;
  typedef enum logic [1:0] {DDRMAP_D256, DDRMAP_D512, DDRMAP_D1G, DDRMAP_DBAD} ddrmap_dens_t;
  typedef enum logic       {DDRMAP_R533, DDRMAP_R667} ddrmap_rate_t;

  localparam logic [2:0] TIM_CL_444 = 3'h4;

  typedef struct packed {
    ddrmap_mode_t mode;
    ddrmap_dens_t dens;
    logic         ecc_en;
    logic [2:0]   cas_lat;
    logic [2:0]   rcd_lat;
    logic [2:0]   rp_lat;
    logic [33:0]  chan_a_bytes;
  } ddrmap_cfg_t;

  typedef struct packed {
    logic        chan;
    logic [32:0] addr;
    logic [2:0]  bank;
    logic [3:0]  burst;
  } ddrmap_route_t;

endpackage : ddrmap_pkg

// ==== design/ddrmap_core.sv ====
// dual-channel ddr2 configuration and address mapping core
// What this block does
// R1: in asymmetric mode all of channel a is mapped first and channel b starts right after it.
// R2: in interleaved mode consecutive 64 byte lines alternate between the two channels.
// R3: every channel runs at one common rate, the slowest installed, and only 533 or 667.
// R4: every access is issued with a burst length of eight in all channel modes.
// R5: four banks are addressed for 512 Mb or smaller devices and eight for 1 Gb devices.
// R6: with two channels up to 64 open pages are tracked at once.
// R7: each channel carries 64 data bits plus eight check bits when ecc is enabled.
// R8: total addressable memory across both channels never exceeds 8 GB.
// R9: only x8 devices of 256 Mb, 512 Mb and 1 Gb are accepted.
// R10: the 667 rate with 4-4-4 timing is refused.
// R11: all operating parameters but the common rate, which follows the dimms, come from a software written control group.
// R12: memory clocks of 266 or 333 MHz plus 2x and 4x come from a pll fed by the host clock.
// R13: the memory pll and its clocks stay off until power good is asserted.
// R14: power good low is a full reset; reset in plus power good is a warm reset.
// R15: refresh is issued early when a channel idles but never later than the interval.
`timescale 1ns/10ps
`default_nettype none

module ddrmap_core #(
  parameter int REFI_CYCLES = ddrmap_pkg::REFI_CYC,
  parameter int PAGE_SLOTS  = ddrmap_pkg::MAX_OPEN_PG
) (
  input  wire logic                      core_clk_i,     // core clock
  input  wire logic                      rst_i,          // sync reset, active high
  input  wire logic                      power_good_in_i,// power good level
  input  wire logic                      reset_in_n_i,   // platform reset, active low
  input  wire logic                      cfg_we_i,       // load control group
  input  wire ddrmap_pkg::ddrmap_cfg_t   cfg_i,          // control group value
  input  wire logic                      dimm_a_i,       // dimm present on channel a
  input  wire logic                      dimm_b_i,       // dimm present on channel b
  input  wire ddrmap_pkg::ddrmap_rate_t  rate_a_i,       // fastest rate of channel a dimm
  input  wire ddrmap_pkg::ddrmap_rate_t  rate_b_i,       // fastest rate of channel b dimm
  input  wire logic                      req_valid_i,    // access request
  output logic                           req_ready_o,    // request taken
  input  wire logic [32:0]               req_addr_i,     // system byte address
  input  wire logic [5:0]                req_slot_i,     // open page slot of request
  input  wire logic                      req_close_i,    // close that page
  output ddrmap_pkg::ddrmap_route_t      route_o,        // routed access
  output logic                           route_valid_o,  // route one cycle pulse
  output logic                           range_err_o,    // address beyond memory, pulse
  output logic                           cfg_err_o,      // last write refused, level
  output ddrmap_pkg::ddrmap_rate_t       rate_o,         // common data rate
  output logic [8:0]                     mclk_mhz_o,     // memory clock selected
  output logic                           pll_en_o,       // memory pll enable
  output logic                           mclk_en_o,      // 1x 2x 4x clock enable
  output logic [71:0]                    lane_en_o,      // data and check lanes per channel
  output logic [1:0]                     ref_req_o,      // refresh pulse per channel
  output logic [6:0]                     open_pages_o,   // tracked open pages
  output logic                           warm_rst_o      // warm reset level
);

  // ****************************************
  // parameter checks
  // ****************************************
  initial begin
    if (PAGE_SLOTS < 1 || PAGE_SLOTS > ddrmap_pkg::MAX_OPEN_PG) begin
      $error("page slot count out of range");
    end
    if (REFI_CYCLES < 4) begin
      $error("refresh interval too short");
    end
    if (REFI_CYCLES > 65535) begin
      $error("refresh interval beyond counter width");
    end
  end

  // full reset: power good low resets all state
  logic full_rst;
  assign full_rst = rst_i | ~power_good_in_i; // R14
  assign warm_rst_o = power_good_in_i & ~reset_in_n_i; // R14

  // ****************************************
  // control group
  // ****************************************
  ddrmap_pkg::ddrmap_cfg_t cfg_r;
  logic                    cfg_ok;

  function automatic logic [33:0] dens_bytes(input ddrmap_pkg::ddrmap_dens_t d);
    // one rank of eight x8 devices
    case (d)
      ddrmap_pkg::DDRMAP_D256: dens_bytes = 34'h010000000;
      ddrmap_pkg::DDRMAP_D512: dens_bytes = 34'h020000000;
      ddrmap_pkg::DDRMAP_D1G:  dens_bytes = 34'h040000000;
      default:                 dens_bytes = 34'h000000000;
    endcase
  endfunction

  always_comb begin
    cfg_ok = 1'b1;
    if (cfg_i.dens == ddrmap_pkg::DDRMAP_DBAD) begin
      cfg_ok = 1'b0; // R9
    end
    if (cfg_i.chan_a_bytes > ddrmap_pkg::MAX_BYTES) begin
      cfg_ok = 1'b0; // R8
    end
    if (rate_o == ddrmap_pkg::DDRMAP_R667 && cfg_i.cas_lat == ddrmap_pkg::TIM_CL_444 &&
        cfg_i.rcd_lat == ddrmap_pkg::TIM_CL_444 && cfg_i.rp_lat == ddrmap_pkg::TIM_CL_444) begin
      cfg_ok = 1'b0; // R10
    end
    if (cfg_i.mode != ddrmap_pkg::DDRMAP_SINGLE && !(dimm_a_i && dimm_b_i)) begin
      cfg_ok = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (full_rst) begin
      cfg_r     <= '0;
      cfg_err_o <= 1'b0;
    end else if (cfg_we_i) begin
      cfg_err_o <= ~cfg_ok;
      if (cfg_ok) begin
        cfg_r <= cfg_i; // R11
      end
    end
  end

  // ****************************************
  // common rate and memory clocks
  // ****************************************
  always_comb begin
    rate_o = ddrmap_pkg::DDRMAP_R667;
    if ((dimm_a_i && rate_a_i == ddrmap_pkg::DDRMAP_R533) ||
        (dimm_b_i && rate_b_i == ddrmap_pkg::DDRMAP_R533)) begin
      rate_o = ddrmap_pkg::DDRMAP_R533; // R3
    end
  end

  assign mclk_mhz_o = (rate_o == ddrmap_pkg::DDRMAP_R667) ? 9'h14D : 9'h10A; // R12

  // hold-off avoids enabling clocks on a glitching power good
  logic [4:0] settle_r;
  always_ff @(posedge core_clk_i) begin
    if (full_rst) begin
      settle_r  <= '0;
      pll_en_o  <= 1'b0;
      mclk_en_o <= 1'b0;
    end else begin
      pll_en_o <= 1'b1; // R13
      if (settle_r != 5'(ddrmap_pkg::PG_SETTLE_CYC)) begin
        settle_r <= settle_r + 5'h01;
      end
      mclk_en_o <= (settle_r == 5'(ddrmap_pkg::PG_SETTLE_CYC)); // R12
    end
  end

  // ****************************************
  // lanes
  // ****************************************
  assign lane_en_o = {cfg_r.ecc_en ? 8'hFF : 8'h00, 64'hFFFFFFFFFFFFFFFF}; // R7

  // ****************************************
  // address mapping
  // ****************************************
  logic [34:0] total_bytes;
  logic        in_range;
  // one bit wider so a dual split of a full 8 GB cannot wrap to zero
  assign total_bytes = (cfg_r.mode == ddrmap_pkg::DDRMAP_SINGLE) ?
                       {1'b0, cfg_r.chan_a_bytes} : {cfg_r.chan_a_bytes, 1'b0};
  assign in_range = ({2'b00, req_addr_i} < total_bytes) &&
                    ({1'b0, req_addr_i} < ddrmap_pkg::MAX_BYTES); // R8

  ddrmap_pkg::ddrmap_route_t route_nxt;
  logic [32:0]               line_addr;
  always_comb begin
    route_nxt       = '0;
    route_nxt.burst = 4'(ddrmap_pkg::BURST_LEN); // R4
    line_addr       = req_addr_i;
    case (cfg_r.mode)
      ddrmap_pkg::DDRMAP_ASYM: begin
        if ({1'b0, req_addr_i} >= cfg_r.chan_a_bytes) begin
          route_nxt.chan = 1'b1; // R1
          line_addr      = 33'({1'b0, req_addr_i} - cfg_r.chan_a_bytes); // R1
        end
      end
      ddrmap_pkg::DDRMAP_INTLV: begin
        route_nxt.chan = req_addr_i[ddrmap_pkg::LINE_BIT]; // R2
        line_addr      = {1'b0, req_addr_i[32:ddrmap_pkg::LINE_BIT+1],
                          req_addr_i[ddrmap_pkg::LINE_BIT-1:0]}; // R2
      end
      default: begin
        route_nxt.chan = 1'b0;
      end
    endcase
    route_nxt.addr = line_addr;
    // bank bits sit just above the page column
    if (cfg_r.dens == ddrmap_pkg::DDRMAP_D1G) begin
      route_nxt.bank = line_addr[15:13]; // R5
    end else begin
      route_nxt.bank = {1'b0, line_addr[14:13]}; // R5
    end
  end

  assign req_ready_o = ~full_rst;

  always_ff @(posedge core_clk_i) begin
    if (full_rst) begin
      route_o       <= '0;
      route_valid_o <= 1'b0;
      range_err_o   <= 1'b0;
    end else begin
      route_valid_o <= req_valid_i & in_range;
      range_err_o   <= req_valid_i & ~in_range; // R8
      if (req_valid_i && in_range) begin
        route_o <= route_nxt;
      end
    end
  end

  // ****************************************
  // open page tracking
  // ****************************************
  logic [PAGE_SLOTS-1:0] page_open_r;
  logic                  slot_ok;
  assign slot_ok = (32'(req_slot_i) < PAGE_SLOTS) &&
                   (cfg_r.mode != ddrmap_pkg::DDRMAP_SINGLE); // R6

  always_ff @(posedge core_clk_i) begin
    if (full_rst) begin
      page_open_r <= '0;
    end else if (req_valid_i && in_range && slot_ok) begin
      page_open_r[req_slot_i] <= ~req_close_i; // R6
    end
  end

  always_comb begin
    open_pages_o = '0;
    for (int i = 0; i < PAGE_SLOTS; i++) begin
      open_pages_o = open_pages_o + 7'(page_open_r[i]);
    end
  end

  // ****************************************
  // refresh
  // ****************************************
  // issue early on idle to keep busy periods free; never past the interval
  logic [15:0] ref_cnt_r [2];
  logic [1:0]  ch_busy;
  logic [1:0]  ref_fire;
  assign ch_busy[0] = req_valid_i & in_range & ~route_nxt.chan;
  assign ch_busy[1] = req_valid_i & in_range & route_nxt.chan;

  for (genvar c = 0; c < 2; c++) begin : g_ref
    assign ref_fire[c] = (ref_cnt_r[c] >= 16'(REFI_CYCLES - 1)) ||
                         (ref_cnt_r[c] >= 16'(REFI_CYCLES / 2) && !ch_busy[c]); // R15

    refresh_bound_a: assert property (@(posedge core_clk_i) disable iff (full_rst) // R15
      ref_cnt_r[c] < 16'(REFI_CYCLES)) else $error("refresh interval lapsed");
  end

  // both channels in one process so each output bit has a single writer
  always_ff @(posedge core_clk_i) begin
    if (full_rst) begin
      ref_cnt_r[0] <= '0;
      ref_cnt_r[1] <= '0;
      ref_req_o    <= '0;
    end else begin
      ref_req_o <= ref_fire; // R15
      for (int c = 0; c < 2; c++) begin
        ref_cnt_r[c] <= ref_fire[c] ? 16'h0000 : ref_cnt_r[c] + 16'h0001;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_asym_hi;
    req_valid_i && in_range && cfg_r.mode == ddrmap_pkg::DDRMAP_ASYM &&
    {1'b0, req_addr_i} >= cfg_r.chan_a_bytes;
  endsequence

  asym_stack_a: assert property (@(posedge core_clk_i) disable iff (full_rst) // R1
    s_asym_hi |=> route_valid_o && route_o.chan) else $error("stacked address not on b");
  intlv_line_a: assert property (@(posedge core_clk_i) disable iff (full_rst) // R2
    req_valid_i && in_range && cfg_r.mode == ddrmap_pkg::DDRMAP_INTLV
    |=> route_o.chan == $past(req_addr_i[6])) else $error("interleave channel wrong");
  common_rate_a: assert property (@(posedge core_clk_i) disable iff (full_rst) // R3
    (dimm_b_i && rate_b_i == ddrmap_pkg::DDRMAP_R533) |-> rate_o == ddrmap_pkg::DDRMAP_R533)
    else $error("rate above slowest dimm");
  range_err_a: assert property (@(posedge core_clk_i) disable iff (full_rst) // R8
    req_valid_i && {2'b00, req_addr_i} >= total_bytes |=> range_err_o && !route_valid_o)
    else $error("out of range request routed");
  burst_eight_a: assert property (@(posedge core_clk_i) disable iff (full_rst) // R4
    route_valid_o |-> route_o.burst == 4'h8) else $error("burst not eight");
  bank_count_a: assert property (@(posedge core_clk_i) disable iff (full_rst) // R5
    route_valid_o && cfg_r.dens != ddrmap_pkg::DDRMAP_D1G |-> !route_o.bank[2])
    else $error("small device given eight banks");
  open_pages_a: assert property (@(posedge core_clk_i) disable iff (full_rst) // R6
    open_pages_o <= 7'(PAGE_SLOTS)) else $error("too many open pages");
  max_mem_a: assert property (@(posedge core_clk_i) disable iff (full_rst) // R8
    route_valid_o |-> route_o.addr < 33'h1FFFFFFFF || !route_o.chan)
    else $error("address beyond 8 GB");
  no_444_a: assert property (@(posedge core_clk_i) disable iff (full_rst) // R10
    !(cfg_we_i && rate_o == ddrmap_pkg::DDRMAP_R667 && cfg_i.cas_lat == 3'h4 &&
      cfg_i.rcd_lat == 3'h4 && cfg_i.rp_lat == 3'h4) or ##1 cfg_err_o)
    else $error("667 4-4-4 accepted");
  pll_gate_a: assert property (@(posedge core_clk_i) // R13
    !power_good_in_i |=> !pll_en_o && !mclk_en_o) else $error("clocks on without power good");

endmodule : ddrmap_core

`default_nettype wire

// ==== dv/ddrmap_dimm_model.sv ====
// model of the unbuffered dimm pair: presence and rated speed per channel
`timescale 1ns/10ps
`default_nettype none
module ddrmap_dimm_model (
  input  wire logic               core_clk_i, // core clock
  input  wire logic [1:0]         pop_i,      // fitted slots, b then a
  input  wire logic [1:0]         spd_i,      // 667 capable, b then a
  output logic                    dimm_a_o,   // present on a
  output logic                    dimm_b_o,   // present on b
  output ddrmap_pkg::ddrmap_rate_t rate_a_o,  // rate of a
  output ddrmap_pkg::ddrmap_rate_t rate_b_o   // rate of b
);
  // ****************************************
  // slot straps
  // ****************************************
  // an empty slot reports the slow grade, never a stale fast one
  always_ff @(posedge core_clk_i) begin
    dimm_a_o <= pop_i[0];
    dimm_b_o <= pop_i[1];
    rate_a_o <= ddrmap_pkg::ddrmap_rate_t'(pop_i[0] & spd_i[0]);
    rate_b_o <= ddrmap_pkg::ddrmap_rate_t'(pop_i[1] & spd_i[1]);
  end
endmodule // ddrmap_dimm_model
`default_nettype wire

// ==== dv/ddrmap_core_tb_top.sv ====
// self-checking bench for the ddr2 mapping core
`timescale 1ns/10ps
`default_nettype none
module ddrmap_core_tb_top;
  localparam int REFI = 40;
  logic core_clk_i = 1'b0, rst_i = 1'b1, pg = 1'b1, rst_n = 1'b1, we = 1'b0;
  logic rv = 1'b0, rcl = 1'b0;
  logic [32:0] ra = '0;
  logic [5:0] rs = '0;
  logic [1:0] pop = 2'h3, spd = 2'h3;
  ddrmap_pkg::ddrmap_cfg_t cfg = '0, cur = '0;
  ddrmap_pkg::ddrmap_route_t route;
  ddrmap_pkg::ddrmap_rate_t rate, rta, rtb;
  logic dma, dmb, rdy, rvo, rerr, cerr, pll, mclk, warm;
  logic [8:0] mhz;
  logic [71:0] lanes;
  logic [1:0] refq;
  logic [6:0] pages;
  int miscompares = 0, n_tests = 0, seed = 27879, n;

  always #2 core_clk_i = ~core_clk_i;

  ddrmap_dimm_model i_dimm (.core_clk_i(core_clk_i), .pop_i(pop), .spd_i(spd),
    .dimm_a_o(dma), .dimm_b_o(dmb), .rate_a_o(rta), .rate_b_o(rtb));

  ddrmap_core #(.REFI_CYCLES(REFI)) i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .power_good_in_i(pg), .reset_in_n_i(rst_n), .cfg_we_i(we), .cfg_i(cfg),
    .dimm_a_i(dma), .dimm_b_i(dmb), .rate_a_i(rta), .rate_b_i(rtb),
    .req_valid_i(rv), .req_ready_o(rdy), .req_addr_i(ra), .req_slot_i(rs),
    .req_close_i(rcl), .route_o(route), .route_valid_o(rvo), .range_err_o(rerr),
    .cfg_err_o(cerr), .rate_o(rate), .mclk_mhz_o(mhz), .pll_en_o(pll),
    .mclk_en_o(mclk), .lane_en_o(lanes), .ref_req_o(refq), .open_pages_o(pages),
    .warm_rst_o(warm));

  // ****************************************
  // checking and closing
  // ****************************************
  task automatic final_report();
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic ddrmap_pkg::ddrmap_cfg_t mk(input int m, input int d, input logic e,
      input logic [2:0] l, input logic [33:0] b);
    mk = '{ddrmap_pkg::ddrmap_mode_t'(m), ddrmap_pkg::ddrmap_dens_t'(d), e, l, l, l, b};
  endfunction

  task automatic set_cfg(input ddrmap_pkg::ddrmap_cfg_t c, input logic bad);
    cfg = c;
    we = 1'b1;
    @(negedge core_clk_i);
    we = 1'b0;
    chk(cerr, bad);
    if (!bad) cur = c;
    // one idle cycle so the next write raises the strobe at a later step
    @(negedge core_clk_i);
  endtask

  // expected route worked out from the mode, density and split point
  task automatic do_req(input logic [32:0] a, input logic [5:0] s, input logic cl);
    ddrmap_pkg::ddrmap_route_t e;
    logic [34:0] tot;
    logic [32:0] m;
    logic err;
    tot = 35'(cur.chan_a_bytes);
    if (cur.mode != ddrmap_pkg::DDRMAP_SINGLE) tot = tot << 1;
    err = 35'(a) >= tot;
    e.chan = 1'b0;
    m = a;
    if (cur.mode == ddrmap_pkg::DDRMAP_ASYM && 34'(a) >= cur.chan_a_bytes) begin
      e.chan = 1'b1;
      m = a - cur.chan_a_bytes[32:0];
    end
    if (cur.mode == ddrmap_pkg::DDRMAP_INTLV) begin
      e.chan = a[6];
      m = {1'b0, a[32:7], a[5:0]};
    end
    e.addr = m;
    e.bank = (cur.dens == ddrmap_pkg::DDRMAP_D1G) ? m[15:13] : {1'b0, m[14:13]};
    e.burst = 4'h8;
    rv = 1'b1;
    ra = a;
    rs = s;
    rcl = cl;
    @(negedge core_clk_i);
    chk(rdy, 1'b1);
    chk({rerr, rvo}, {err, !err});
    if (!err) chk(route, e);
    rv = 1'b0;
    @(negedge core_clk_i);
    chk({rerr, rvo}, 2'h0);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (12) @(negedge core_clk_i);
    rst_i = 1'b0;
    @(negedge core_clk_i);
    chk(pll, 1'b1);
    repeat (13) @(negedge core_clk_i);
    chk(mclk, 1'b0);
    repeat (6) @(negedge core_clk_i);
    chk(mclk, 1'b1);
    for (int i = 0; i < 4; i++) begin
      spd = 2'(i);
      repeat (2) @(negedge core_clk_i);
      chk(rate, i == 3);
      chk(mhz, (i == 3) ? 9'h14D : 9'h10A);
    end
    set_cfg(mk(0, 3, 1'b0, 3'h5, 34'h100000000), 1'b1);
    set_cfg(mk(0, 0, 1'b0, 3'h5, 34'h200000001), 1'b1);
    set_cfg(mk(0, 0, 1'b0, 3'h5, 34'h200000000), 1'b0);
    set_cfg(mk(0, 1, 1'b0, 3'h4, 34'h100000000), 1'b1);
    spd = 2'h1;
    repeat (2) @(negedge core_clk_i);
    set_cfg(mk(0, 1, 1'b0, 3'h4, 34'h100000000), 1'b0);
    spd = 2'h3;
    pop = 2'h1;
    repeat (2) @(negedge core_clk_i);
    set_cfg(mk(2, 1, 1'b0, 3'h5, 34'h080000000), 1'b1);
    pop = 2'h3;
    repeat (2) @(negedge core_clk_i);
    // close requests keep the page table empty for the count test below
    for (int md = 0; md < 3; md++)
      for (int d = 0; d < 3; d++) begin
        set_cfg(mk(md, d, d[0], 3'h5, md ? 34'h080000000 : 34'h100000000), 1'b0);
        chk(lanes, {{8{d[0]}}, {64{1'b1}}});
        do_req(33'(cur.chan_a_bytes - 34'h1), 6'h00, 1'b1);
        do_req(33'(cur.chan_a_bytes), 6'h00, 1'b1);
        do_req(33'h000000040, 6'h00, 1'b1);
        for (int k = 0; k < 40; k++)
          do_req(33'({$random(seed), $random(seed)}), 6'($random(seed)), 1'b1);
      end
    for (int k = 0; k < 65; k++) do_req(33'h0, 6'(k), 1'b0);
    @(negedge core_clk_i);
    chk(pages, 7'h40);
    do_req(33'h0, 6'h05, 1'b1);
    @(negedge core_clk_i);
    chk(pages, 7'h3F);
    for (int ch = 0; ch < 2; ch++) begin
      n = 0;
      while (!refq[ch] && n < 60) begin
        @(negedge core_clk_i);
        n++;
      end
      n = 0;
      do begin
        @(negedge core_clk_i);
        n++;
      end while (!refq[ch] && n < 60);
      chk(n >= REFI / 2 && n <= REFI, 1'b1);
    end
    rst_n = 1'b0;
    @(negedge core_clk_i);
    chk(warm, 1'b1);
    rst_n = 1'b1;
    pg = 1'b0;
    @(negedge core_clk_i);
    chk({warm, pll, mclk, pages}, 10'h0);
    pg = 1'b1;
    cur = '0;
    do_req(33'h0, 6'h00, 1'b0);
    final_report();
  end

  // the whole run takes about a thousand cycles
  initial begin
    #100000;
    miscompares++;
    final_report();
  end
endmodule // ddrmap_core_tb_top
`default_nettype wire
